/* File: verilog/pulse_accumulator.sv */
`timescale 1ns/1ps
`default_nettype none

module pulse_accumulator
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // pins and timer side
    input wire logic shared_channel7_pin,
    input wire logic prescaler_tick,
    input wire logic prescaler_div64_tick,
    // outputs
    output logic timer_count_tick,
    output logic overflow_irq,
    output logic input_edge_irq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    pacc_pkg::bus_req_t req;
    logic [7:0] accum_control_r;
    logic [1:0] accum_flags_r;
    logic [15:0] accum_count_r;
    logic [7:0] timer_ctrl_r;
    logic [1:0] pin_sync_r;
    logic pin_prev_r;
    logic [15:0] div_r;
    logic [15:0] count_nxt;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic accum_enable;
    logic accum_mode_select;
    logic count_polarity;
    logic main_timer_enable;
    logic fast_flag_clear;
    pacc_pkg::clk_sel_t clk_sel;
    assign accum_enable = accum_control_r[pacc_pkg::BIT_ENABLE];
    assign accum_mode_select = accum_control_r[pacc_pkg::BIT_MODE];
    assign count_polarity = accum_control_r[pacc_pkg::BIT_POLARITY];
    assign clk_sel = pacc_pkg::clk_sel_t'(
        accum_control_r[pacc_pkg::BIT_CLKSEL_HI:pacc_pkg::BIT_CLKSEL_LO]);
    assign main_timer_enable = timer_ctrl_r[pacc_pkg::BIT_TIMER_EN];
    assign fast_flag_clear = timer_ctrl_r[pacc_pkg::BIT_FAST_CLR];

    // ----------------------------------------------------------------
    // pin synchroniser and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pin_sync_r <= 2'h0;
            pin_prev_r <= 1'b0;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[0], shared_channel7_pin};
            pin_prev_r <= pin_sync_r[1];
        end
    end

    logic rise;
    logic fall;
    logic pin_level;
    assign pin_level = pin_sync_r[1];
    assign rise = pin_level & ~pin_prev_r;
    assign fall = ~pin_level & pin_prev_r;

    // ----------------------------------------------------------------
    // counting events
    // ----------------------------------------------------------------
    logic event_edge;
    logic gate_active;
    logic gate_trailing;
    logic count_inc;
    logic flag_edge_set;
    // event mode needs no timer clock, so it counts with the timer stopped
    assign event_edge = count_polarity ? rise : fall;
    // polarity 0 gates on high level, so the trailing edge is a fall
    assign gate_active = count_polarity ? ~pin_level : pin_level;
    assign gate_trailing = count_polarity ? rise : fall;
    always_comb
    begin
        count_inc = 1'b0;
        flag_edge_set = 1'b0;
        if (accum_enable)
        begin
            if (!accum_mode_select)
            begin
                count_inc = event_edge;
                flag_edge_set = event_edge;
            end
            else
            begin
                // div-64 tick only exists while the timer prescaler runs
                count_inc = gate_active & prescaler_div64_tick & main_timer_enable;
                flag_edge_set = gate_trailing;
            end
        end
    end

    logic count_acc;
    logic count_wr;
    assign count_acc = (req.wr | req.rd) &
        (req.addr == pacc_pkg::OFS_COUNT_WORD || req.addr == pacc_pkg::OFS_COUNT_HIGH ||
         req.addr == pacc_pkg::OFS_COUNT_LOW);
    assign count_wr = req.wr & count_acc;

    always_comb
    begin
        count_nxt = accum_count_r;
        if (count_wr && req.addr == pacc_pkg::OFS_COUNT_WORD)
            count_nxt = req.wdata;
        else if (count_wr && req.addr == pacc_pkg::OFS_COUNT_HIGH)
            count_nxt = {req.wdata[7:0], accum_count_r[7:0]};
        else if (count_wr)
            count_nxt = {accum_count_r[15:8], req.wdata[7:0]};
        else if (count_inc)
            count_nxt = accum_count_r + 16'h0001;
    end

    logic overflow_evt;
    assign overflow_evt = !count_wr && count_inc &&
        accum_count_r == pacc_pkg::COUNT_MAX;

    always_ff @(posedge mclk)
    begin
        if (srst)
            accum_count_r <= pacc_pkg::RST_COUNT;
        else
            accum_count_r <= count_nxt;
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            accum_control_r <= pacc_pkg::RST_CONTROL;
            timer_ctrl_r <= pacc_pkg::RST_CONTROL;
        end
        else if (req.wr)
        begin
            if (req.addr == pacc_pkg::OFS_CONTROL)
                accum_control_r <= {1'b0, req.wdata[6:0]};
            if (req.addr == pacc_pkg::OFS_TIMER_CTRL)
                timer_ctrl_r <= req.wdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // flags: a set in the same cycle as a clear wins
    // ----------------------------------------------------------------
    logic [1:0] flag_clr;
    logic [1:0] flag_set;
    always_comb
    begin
        flag_clr = 2'h0;
        if (req.wr && req.addr == pacc_pkg::OFS_FLAGS)
            flag_clr = req.wdata[1:0];
        if (count_acc && fast_flag_clear)
            flag_clr = 2'h3;
        flag_set = 2'h0;
        flag_set[pacc_pkg::BIT_OVF_FLAG] = overflow_evt;
        flag_set[pacc_pkg::BIT_EDGE_FLAG] = flag_edge_set;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            accum_flags_r <= pacc_pkg::RST_FLAGS;
        else
            accum_flags_r <= (accum_flags_r & ~flag_clr) | flag_set;
    end

    // ----------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            overflow_irq <= 1'b0;
            input_edge_irq <= 1'b0;
        end
        else
        begin
            overflow_irq <= accum_flags_r[pacc_pkg::BIT_OVF_FLAG] &
                accum_control_r[pacc_pkg::BIT_OVF_IRQ_EN];
            input_edge_irq <= accum_flags_r[pacc_pkg::BIT_EDGE_FLAG] &
                accum_control_r[pacc_pkg::BIT_EDGE_IRQ_EN];
        end
    end

    // ----------------------------------------------------------------
    // timer counter clock source
    // ----------------------------------------------------------------
    // divider only advances on accumulator ticks
    always_ff @(posedge mclk)
    begin
        if (srst)
            div_r <= 16'h0000;
        else if (count_inc)
            div_r <= div_r + 16'h0001;
    end

    logic tick_sel;
    always_comb
    begin
        tick_sel = prescaler_tick;
        if (accum_enable)
        begin
            case (clk_sel)
                pacc_pkg::CLK_PRESCALER: tick_sel = prescaler_tick;
                pacc_pkg::CLK_ACCUM: tick_sel = count_inc;
                pacc_pkg::CLK_ACCUM_DIV256:
                    tick_sel = count_inc && (&div_r[pacc_pkg::DIV_256_BITS-1:0]);
                pacc_pkg::CLK_ACCUM_DIV65536:
                    tick_sel = count_inc && (&div_r[pacc_pkg::DIV_65536_BITS-1:0]);
                default: tick_sel = prescaler_tick;
            endcase
        end
    end

    // selection reads the live field, so a write switches on the next cycle
    always_ff @(posedge mclk)
    begin
        if (srst)
            timer_count_tick <= 1'b0;
        else
            timer_count_tick <= tick_sel;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
            rdata <= 16'h0000;
        else if (req.rd)
        begin
            case (req.addr)
                pacc_pkg::OFS_CONTROL: rdata <= {8'h00, accum_control_r};
                pacc_pkg::OFS_FLAGS: rdata <= {14'h0000, accum_flags_r};
                pacc_pkg::OFS_COUNT_HIGH: rdata <= {8'h00, accum_count_r[15:8]};
                pacc_pkg::OFS_COUNT_LOW: rdata <= {8'h00, accum_count_r[7:0]};
                pacc_pkg::OFS_COUNT_WORD: rdata <= accum_count_r;
                pacc_pkg::OFS_TIMER_CTRL: rdata <= {8'h00, timer_ctrl_r};
                default: rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end

endmodule : pulse_accumulator

`default_nettype wire

/* File: verilog/pacc_pkg.sv */
package pacc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h21;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h22;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h23;
    localparam logic [7:0] OFS_COUNT_WORD = 8'h24;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h26;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE = 6;
    localparam int BIT_MODE = 5;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_CLKSEL_HI = 3;
    localparam int BIT_CLKSEL_LO = 2;
    localparam int BIT_OVF_IRQ_EN = 1;
    localparam int BIT_EDGE_IRQ_EN = 0;
    localparam int BIT_OVF_FLAG = 1;
    localparam int BIT_EDGE_FLAG = 0;
    localparam int BIT_TIMER_EN = 7;
    localparam int BIT_FAST_CLR = 4;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam int GATE_DIVIDE = 64;
    localparam int DIV_256_BITS = 8;
    localparam int DIV_65536_BITS = 16;

    typedef enum logic [1:0] {
        CLK_PRESCALER,
        CLK_ACCUM,
        CLK_ACCUM_DIV256,
        CLK_ACCUM_DIV65536
    } clk_sel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage : pacc_pkg

/* File: test/pin_source.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// pin source: idle low, every level lasts well over two clocks
// ------------------------------------------------------------
module pin_source
(
    // clock
    input wire logic mclk,
    // shared pin
    output logic pin
);
    initial pin = 1'b0;

    task automatic pulse(input int n, input int w);
        repeat (n)
        begin
            pin <= 1'b1;
            repeat (w) @(posedge mclk);
            pin <= 1'b0;
            repeat (w) @(posedge mclk);
        end
    endtask : pulse
endmodule : pin_source

`default_nettype wire

/* File: test/pulse_accumulator_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module pulse_accumulator_checker
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic prescaler_tick,
    input wire logic timer_count_tick,
    input wire logic overflow_irq,
    input wire logic input_edge_irq
);
    logic [7:0] ctl_r;
    logic ffc_r;
    logic pre_sel;
    logic flg_wr;
    logic cnt_acc;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // control shadow rebuilt from bus writes, bit 7 never stored
    always_ff @(posedge mclk)
    begin
        if (srst)
            ctl_r <= 8'h00;
        else if (wr && addr == pacc_pkg::OFS_CONTROL)
            ctl_r <= {1'b0, wdata[6:0]};
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            ffc_r <= 1'b0;
        else if (wr && addr == pacc_pkg::OFS_TIMER_CTRL)
            ffc_r <= wdata[4];
    end

    assign pre_sel = !ctl_r[6] || ctl_r[3:2] == 2'h0;
    assign flg_wr = wr && addr == pacc_pkg::OFS_FLAGS;
    assign cnt_acc = (wr || rd) && addr == pacc_pkg::OFS_COUNT_WORD;

    property p_rd_idle;
        !rd |=> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
    property p_ctl_rd;
        rd && addr == pacc_pkg::OFS_CONTROL |=> rdata == {8'h00, ctl_r};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback");
    property p_ovf_en;
        overflow_irq |-> $past(ctl_r[1]);
    endproperty
    a_ovf_en: assert property (p_ovf_en) else $error("overflow irq masked");
    property p_edge_en;
        input_edge_irq |-> $past(ctl_r[0]);
    endproperty
    a_edge_en: assert property (p_edge_en) else $error("edge irq masked");
    // holds from the cycle after the write, no counter boundary waited for
    property p_pre_sel;
        pre_sel |=> timer_count_tick == $past(prescaler_tick);
    endproperty
    a_pre_sel: assert property (p_pre_sel) else $error("timer clock source");
    property p_ovf_clr;
        flg_wr && wdata[1] |=> ##1 !overflow_irq;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
    property p_edge_clr;
        flg_wr && wdata[0] |=> ##1 !input_edge_irq;
    endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge not cleared");
    property p_fast_clr;
        cnt_acc && ffc_r |=> ##1 !overflow_irq && !input_edge_irq;
    endproperty
    a_fast_clr: assert property (p_fast_clr) else $error("fast clear failed");

    c_ovf: cover property (overflow_irq);
    c_acc_tick: cover property (timer_count_tick && !pre_sel);
    c_fast: cover property (cnt_acc && ffc_r);
endmodule : pulse_accumulator_checker

bind pulse_accumulator pulse_accumulator_checker pulse_accumulator_checker_inst (.*);

`default_nettype wire

/* File: test/pulse_accumulator_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module pulse_accumulator_tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pre = 1'b0;
    logic d64 = 1'b0;
    logic [15:0] rdata;
    logic [15:0] v;
    logic pin;
    logic tick;
    logic ovf_irq;
    logic edge_irq;
    int cyc = 0;
    int nt = 0;
    int n0;
    int fails = 0;
    int cmp_count = 0;

    always #50 mclk = ~mclk;

    // div64 left ungated here so the internal timer gating is exercised
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        pre <= cyc % 4 == 3;
        d64 <= cyc % 64 == 63;
        if (tick)
            nt <= nt + 1;
        if (cyc > 60000)
        begin
            fails++;
            report_and_stop();
        end
    end

    pulse_accumulator pulse_accumulator_inst (.mclk(mclk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .shared_channel7_pin(pin),
        .prescaler_tick(pre), .prescaler_div64_tick(d64), .timer_count_tick(tick),
        .overflow_irq(ovf_irq), .input_edge_irq(edge_irq));
    pin_source pin_source_inst (.mclk(mclk), .pin(pin));

    task automatic wrr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wrr

    task automatic rdx(input logic [7:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rdx

    task automatic rdv(input logic [7:0] a, input logic [15:0] e);
        rdx(a);
        `CHK(v, e)
    endtask : rdv

    task automatic t_event;
        for (int p = 0; p < 2; p++)
        begin
            wrr(pacc_pkg::OFS_CONTROL, p ? 16'h0050 : 16'h0040);
            wrr(pacc_pkg::OFS_COUNT_WORD, 16'hfffe);
            pin_source_inst.pulse(3, 4);
            repeat (8) @(posedge mclk);
            rdv(pacc_pkg::OFS_COUNT_WORD, 16'h0001);
            rdv(pacc_pkg::OFS_FLAGS, 16'h0003);
            wrr(pacc_pkg::OFS_FLAGS, 16'h0003);
        end
    endtask : t_event

    task automatic t_flags;
        wrr(pacc_pkg::OFS_CONTROL, 16'h0043);
        wrr(pacc_pkg::OFS_COUNT_WORD, 16'hffff);
        pin_source_inst.pulse(1, 4);
        repeat (8) @(posedge mclk);
        `CHK(ovf_irq, 1'b1)
        `CHK(edge_irq, 1'b1)
        wrr(pacc_pkg::OFS_FLAGS, 16'h0000);
        rdv(pacc_pkg::OFS_FLAGS, 16'h0003);
        wrr(pacc_pkg::OFS_FLAGS, 16'h0001);
        rdv(pacc_pkg::OFS_FLAGS, 16'h0002);
        wrr(pacc_pkg::OFS_FLAGS, 16'h0002);
        rdv(pacc_pkg::OFS_FLAGS, 16'h0000);
        pin_source_inst.pulse(1, 4);
        repeat (8) @(posedge mclk);
        wrr(pacc_pkg::OFS_TIMER_CTRL, 16'h0010);
        rdv(pacc_pkg::OFS_COUNT_WORD, 16'h0001);
        rdv(pacc_pkg::OFS_FLAGS, 16'h0000);
        wrr(pacc_pkg::OFS_TIMER_CTRL, 16'h0000);
        wrr(pacc_pkg::OFS_COUNT_LOW, 16'h0012);
        rdv(pacc_pkg::OFS_COUNT_WORD, 16'h0012);
        wrr(pacc_pkg::OFS_COUNT_HIGH, 16'h0034);
        rdv(pacc_pkg::OFS_COUNT_HIGH, 16'h0034);
        rdv(pacc_pkg::OFS_COUNT_LOW, 16'h0012);
        rdv(pacc_pkg::OFS_COUNT_WORD, 16'h3412);
    endtask : t_flags

    task automatic t_gated;
        wrr(pacc_pkg::OFS_CONTROL, 16'h0060);
        wrr(pacc_pkg::OFS_COUNT_WORD, 16'h0000);
        pin_source_inst.pulse(1, 200);
        rdv(pacc_pkg::OFS_COUNT_WORD, 16'h0000);
        rdv(pacc_pkg::OFS_FLAGS, 16'h0001);
        wrr(pacc_pkg::OFS_TIMER_CTRL, 16'h0080);
        pin_source_inst.pulse(1, 256);
        rdx(pacc_pkg::OFS_COUNT_WORD);
        `CHK(v >= 16'h0003 && v <= 16'h0005, 1'b1)
        wrr(pacc_pkg::OFS_CONTROL, 16'h0070);
        wrr(pacc_pkg::OFS_COUNT_WORD, 16'h0000);
        repeat (256) @(posedge mclk);
        rdx(pacc_pkg::OFS_COUNT_WORD);
        `CHK(v >= 16'h0003 && v <= 16'h0005, 1'b1)
        wrr(pacc_pkg::OFS_TIMER_CTRL, 16'h0000);
    endtask : t_gated

    task automatic t_clksel;
        wrr(pacc_pkg::OFS_CONTROL, 16'h0044);
        // ticks launched under the old selection still land for one edge
        repeat (2) @(posedge mclk);
        n0 = nt;
        pin_source_inst.pulse(3, 4);
        repeat (8) @(posedge mclk);
        `CHK(nt - n0, 3)
        wrr(pacc_pkg::OFS_CONTROL, 16'h0048);
        n0 = nt;
        pin_source_inst.pulse(300, 3);
        repeat (8) @(posedge mclk);
        `CHK((nt - n0) inside {1, 2}, 1'b1)
        wrr(pacc_pkg::OFS_CONTROL, 16'h000c);
        repeat (2) @(posedge mclk);
        n0 = nt;
        repeat (40) @(posedge mclk);
        `CHK(nt - n0, 10)
    endtask : t_clksel

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        rdv(pacc_pkg::OFS_COUNT_WORD, 16'h0000);
        wrr(pacc_pkg::OFS_CONTROL, 16'h00ff);
        rdv(pacc_pkg::OFS_CONTROL, 16'h007f);
        rdv(8'h30, 16'h0000);
        t_event();
        t_flags();
        t_gated();
        t_clksel();
        report_and_stop();
    end
endmodule : pulse_accumulator_tb_top

`default_nettype wire
